// ==== logic/fconv_defs.svh ====
/*
  constants of the unsigned float convert unit: opcodes, flag bit
  positions, register offsets, status word layout and reset values.
  assumes inclusion by bare name from the logic files.
*/
`ifndef FCONV_DEFS_SVH
`define FCONV_DEFS_SVH

// ----------------------------------------------------------------
// opcodes
// ----------------------------------------------------------------
`define OPC_FTOU_RZ_FLAGS 8'h7E
`define OPC_UTOF          8'h7F
`define OPC_UTOF_FLAGS    8'h80

// ----------------------------------------------------------------
// exception flag vector layout
// ----------------------------------------------------------------
`define FLAGS_W      7
`define FLG_DIVIDE_BY_ZERO      0
`define FLG_INEXACT             1
`define FLG_UNDERFLOW           2
`define FLG_OVERFLOW            3
`define FLG_INVALID             4
`define FLG_INPUT_FLUSHED_ZERO  5
`define FLG_OUTPUT_FLUSHED_ZERO 6

// ----------------------------------------------------------------
// float field constants
// ----------------------------------------------------------------
`define EXP_BIAS     8'h7F
`define EXP_U32_LIM  8'h9F
`define EXP_TOP      8'h9E

// ----------------------------------------------------------------
// register offsets and status word layout
// ----------------------------------------------------------------
`define REG_PSW      8'h00
`define REG_PIPE     8'h04
`define REG_RETIRED  8'h08
`define PSW_RM_LSB   8
`define PSW_RESET    32'h0000_0000

`endif

// ==== logic/fconv_pkg.sv ====
/*
  types of the unsigned float convert unit.
  assumes nothing beyond the defs header.
*/
`default_nettype none

package fconv_pkg;

  // ----------------------------------------------------------------
  // operation kinds and rounding modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    OP_NONE,
    OP_FTOU_FLAGS,
    OP_UTOF,
    OP_UTOF_FLAGS
  } op_kind_t;

  typedef enum logic [1:0] {
    RM_NEAREST,
    RM_ZERO,
    RM_POS,
    RM_NEG
  } rmode_t;

  typedef logic [6:0] flags_t;

endpackage

`default_nettype wire

// ==== logic/ftou_flags.sv ====
/*
  combinational flags of a float to unsigned conversion that truncates.
  assumes a single-precision source; result is the flag vector.
*/
`default_nettype none
`include "fconv_defs.svh"

module ftou_flags (
  input  wire logic [31:0]       src,
  output fconv_pkg::flags_t      flags
);
  import fconv_pkg::*;

  // ----------------------------------------------------------------
  // field decode
  // ----------------------------------------------------------------
  wire logic        sign    = src[31];
  wire logic [7:0]  expo    = src[30:23];
  wire logic [22:0] man     = src[22:0];
  wire logic        is_zexp = (expo == 8'h00);
  wire logic        is_max  = (expo == 8'hFF);
  wire logic        ge_one  = (expo >= `EXP_BIAS);
  wire logic        too_big = (expo >= `EXP_U32_LIM);
  wire logic [7:0]  sh      = expo - `EXP_BIAS;
  wire logic [22:0] lostmsk = (sh >= 8'h17) ? 23'h000000 :
                              (23'h7FFFFF >> sh[4:0]);
  wire logic        frac_nz = |(man & lostmsk);

  // ----------------------------------------------------------------
  // classification
  // ----------------------------------------------------------------
  wire logic input_flushed_zero_flag =
               is_zexp & (man != 23'h000000);
  wire logic invalid_flag = ~is_zexp & (is_max | (sign & ge_one)
                     | (~sign & too_big));
  wire logic inexact_flag = ~is_zexp & ~invalid_flag
                            & (~ge_one | frac_nz);

  always_comb begin
    flags = '0;
    flags[`FLG_INPUT_FLUSHED_ZERO] = input_flushed_zero_flag;
    flags[`FLG_INVALID] = invalid_flag;
    flags[`FLG_INEXACT] = inexact_flag;
  end

endmodule

`default_nettype wire

// ==== logic/utof_round.sv ====
/*
  combinational unsigned to single-precision conversion with the four
  rounding modes, plus the inexact flag.
  assumes the rounding mode is stable with the source.
*/
`default_nettype none
`include "fconv_defs.svh"

module utof_round (
  input  wire logic [31:0]       src,
  input  wire fconv_pkg::rmode_t rm,
  output logic [31:0]            result,
  output logic                   inexact
);
  import fconv_pkg::*;

  // ----------------------------------------------------------------
  // leading zero count
  // ----------------------------------------------------------------
  function automatic logic [4:0] lead_zeros(input logic [31:0] v);
    logic [4:0] n;
    logic       found;
    n = 5'h00;
    found = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      if (!found && v[i]) begin
        found = 1'b1;
        n = 5'(31 - i);
      end
    end
    return n;
  endfunction

  // ----------------------------------------------------------------
  // normalise, round, pack
  // ----------------------------------------------------------------
  wire logic [4:0]  lz     = lead_zeros(src);
  wire logic [31:0] norm   = src << lz;
  wire logic        nz     = (src != 32'h0000_0000);
  wire logic        lsb    = norm[8];
  wire logic        guard  = norm[7];
  wire logic        sticky = |norm[6:0];
  wire logic [7:0]  expo   = `EXP_TOP - {3'h0, lz};
  logic             up;

  always_comb begin
    unique case (rm)
      RM_NEAREST: up = guard & (sticky | lsb);
      RM_ZERO:    up = 1'b0;
      RM_POS:     up = guard | sticky;
      RM_NEG:     up = 1'b0;
    endcase
  end

  // mantissa carry ripples into the exponent on its own
  assign result  = nz ? ({1'b0, expo, norm[30:8]} + {31'h0, up})
                      : 32'h0000_0000;
  assign inexact = nz & (guard | sticky);

endmodule

`default_nettype wire

// ==== logic/fconv_unit.sv ====
/*
  unsigned float convert unit: two issue slots, three-cycle pipeline,
  status word with sticky exception flags and rounding mode, reached
  over a classic wishbone slave.
  assumes issue logic presents one operation per slot per cycle and
  the register file writes on the one-cycle write strobes.
*/
`default_nettype none
`include "fconv_defs.svh"

module fconv_unit #(
  parameter int DEST_W = 7,
  parameter int ADR_W  = 8
) (
  input  wire logic              MCLK,
  input  wire logic              RSTN,
  // wishbone slave
  input  wire logic              WB_CYC_I,
  input  wire logic              WB_STB_I,
  input  wire logic              WB_WE_I,
  input  wire logic [ADR_W-1:0]  WB_ADR_I,
  input  wire logic [3:0]        WB_SEL_I,
  input  wire logic [31:0]       WB_DAT_I,
  output logic      [31:0]       WB_DAT_O,
  output logic                   WB_ACK_O,
  // issue slot 1
  input  wire logic              S1_ISSUE,
  input  wire logic [7:0]        S1_OPCODE,
  input  wire logic [31:0]       S1_SRC,
  input  wire logic              S1_GUARD_USED,
  input  wire logic [31:0]       S1_GUARD,
  input  wire logic [DEST_W-1:0] S1_DEST,
  // issue slot 4
  input  wire logic              S4_ISSUE,
  input  wire logic [7:0]        S4_OPCODE,
  input  wire logic [31:0]       S4_SRC,
  input  wire logic              S4_GUARD_USED,
  input  wire logic [31:0]       S4_GUARD,
  input  wire logic [DEST_W-1:0] S4_DEST,
  // flag updates of other float units retiring this cycle
  input  wire fconv_pkg::flags_t FLAG_SET_IN,
  // register file write ports
  output logic                   S1_WR_EN,
  output logic      [DEST_W-1:0] S1_WR_DEST,
  output logic      [31:0]       S1_WR_DATA,
  output logic                   S4_WR_EN,
  output logic      [DEST_W-1:0] S4_WR_DEST,
  output logic      [31:0]       S4_WR_DATA,
  // status word view
  output fconv_pkg::flags_t      PSW_FLAGS,
  output fconv_pkg::rmode_t      PSW_ROUND
);
  import fconv_pkg::*;

  localparam int NS = 2;

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic [1:0] rst_sync_reg;
  wire logic  rst_n = rst_sync_reg[1];

  always_ff @(posedge MCLK or negedge RSTN) begin
    if (!RSTN) begin
      rst_sync_reg <= 2'b00;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  // ----------------------------------------------------------------
  // opcode decode
  // ----------------------------------------------------------------
  function automatic op_kind_t decode_op(input logic       issue,
                                         input logic [7:0] opc);
    op_kind_t k;
    k = OP_NONE;
    if (issue) begin
      unique case (opc)
        `OPC_FTOU_RZ_FLAGS: k = OP_FTOU_FLAGS;
        `OPC_UTOF:          k = OP_UTOF;
        `OPC_UTOF_FLAGS:    k = OP_UTOF_FLAGS;
        default:            k = OP_NONE;
      endcase
    end
    return k;
  endfunction

  // ----------------------------------------------------------------
  // slot gathering
  // ----------------------------------------------------------------
  op_kind_t          kind_in [NS];
  logic [31:0]       src_in  [NS];
  logic              gok_in  [NS];
  logic [DEST_W-1:0] dest_in [NS];

  assign kind_in[0] = decode_op(S1_ISSUE, S1_OPCODE);
  assign kind_in[1] = decode_op(S4_ISSUE, S4_OPCODE);
  assign src_in[0]  = S1_SRC;
  assign src_in[1]  = S4_SRC;
  assign gok_in[0]  = ~S1_GUARD_USED | S1_GUARD[0];
  assign gok_in[1]  = ~S4_GUARD_USED | S4_GUARD[0];
  assign dest_in[0] = S1_DEST;
  assign dest_in[1] = S4_DEST;

  // ----------------------------------------------------------------
  // status word
  // ----------------------------------------------------------------
  flags_t flags_reg;
  flags_t flags_next;
  rmode_t rm_reg;
  rmode_t rm_next;

  // ----------------------------------------------------------------
  // stage 1: operands captured at issue
  // ----------------------------------------------------------------
  op_kind_t          kind1_reg [NS];
  logic [31:0]       src1_reg  [NS];
  logic              gok1_reg  [NS];
  logic [DEST_W-1:0] dest1_reg [NS];
  rmode_t            rm1_reg   [NS];

  // ----------------------------------------------------------------
  // stage 2: computed results
  // ----------------------------------------------------------------
  logic              we2_reg   [NS];
  logic [31:0]       data2_reg [NS];
  logic [DEST_W-1:0] dest2_reg [NS];
  flags_t            set2_reg  [NS];

  // ----------------------------------------------------------------
  // stage 3: write port registers
  // ----------------------------------------------------------------
  logic              we3_reg   [NS];
  logic [31:0]       data3_reg [NS];
  logic [DEST_W-1:0] dest3_reg [NS];

  logic [31:0] data2_next [NS];
  flags_t      set2_next  [NS];

  for (genvar s = 0; s < NS; s++) begin : g_slot
    flags_t      ftou_f;
    logic [31:0] utof_res;
    logic        utof_inexact;
    flags_t      utof_f;

    ftou_flags u_ftou (
      .src   (src1_reg[s]),
      .flags (ftou_f)
    );

    utof_round u_utof (
      .src     (src1_reg[s]),
      .rm      (rm1_reg[s]),
      .result  (utof_res),
      .inexact (utof_inexact)
    );

    always_comb begin
      utof_f = '0;
      utof_f[`FLG_INEXACT] = utof_inexact;
    end

    // flag operations only return the vector, status stays put
    assign data2_next[s] =
      (kind1_reg[s] == OP_FTOU_FLAGS) ? {25'h0, ftou_f} :
      (kind1_reg[s] == OP_UTOF_FLAGS) ? {25'h0, utof_f} :
      utof_res;
    assign set2_next[s] =
      (kind1_reg[s] == OP_UTOF && gok1_reg[s]) ? utof_f
                                               : '0;
  end

  // ----------------------------------------------------------------
  // pipeline advance
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      for (int s = 0; s < NS; s++) begin
        kind1_reg[s] <= OP_NONE;
        src1_reg[s]  <= 32'h0000_0000;
        gok1_reg[s]  <= 1'b0;
        dest1_reg[s] <= '0;
        rm1_reg[s]   <= RM_NEAREST;
        we2_reg[s]   <= 1'b0;
        data2_reg[s] <= 32'h0000_0000;
        dest2_reg[s] <= '0;
        set2_reg[s]  <= '0;
        we3_reg[s]   <= 1'b0;
        data3_reg[s] <= 32'h0000_0000;
        dest3_reg[s] <= '0;
      end
    end else begin
      for (int s = 0; s < NS; s++) begin
        kind1_reg[s] <= kind_in[s];
        src1_reg[s]  <= src_in[s];
        gok1_reg[s]  <= gok_in[s];
        dest1_reg[s] <= dest_in[s];
        rm1_reg[s]   <= rm_reg;
        we2_reg[s]   <= (kind1_reg[s] != OP_NONE) & gok1_reg[s];
        data2_reg[s] <= data2_next[s];
        dest2_reg[s] <= dest1_reg[s];
        set2_reg[s]  <= set2_next[s];
        we3_reg[s]   <= we2_reg[s];
        data3_reg[s] <= data2_reg[s];
        dest3_reg[s] <= dest2_reg[s];
      end
    end
  end

  // ----------------------------------------------------------------
  // register file write ports
  // ----------------------------------------------------------------
  assign S1_WR_EN   = we3_reg[0];
  assign S1_WR_DEST = dest3_reg[0];
  assign S1_WR_DATA = data3_reg[0];
  assign S4_WR_EN   = we3_reg[1];
  assign S4_WR_DEST = dest3_reg[1];
  assign S4_WR_DATA = data3_reg[1];

  // ----------------------------------------------------------------
  // wishbone slave
  // ----------------------------------------------------------------
  logic        ack_reg;
  logic [31:0] dat_o_reg;
  logic [31:0] retired_reg;

  wire logic access  = WB_CYC_I & WB_STB_I;
  wire logic hit_psw = (WB_ADR_I == ADR_W'(`REG_PSW));
  wire logic hit_pip = (WB_ADR_I == ADR_W'(`REG_PIPE));
  wire logic hit_ret = (WB_ADR_I == ADR_W'(`REG_RETIRED));
  wire logic psw_wr  = access & WB_WE_I & ack_reg & hit_psw;

  wire logic [5:0] pipe_busy = {we3_reg[1], we3_reg[0],
                                we2_reg[1], we2_reg[0],
                                kind1_reg[1] != OP_NONE,
                                kind1_reg[0] != OP_NONE};
  wire logic [31:0] psw_word = {22'h0, rm_reg, 1'b0, flags_reg};
  wire logic [31:0] rd_mux   = hit_psw ? psw_word :
                               hit_pip ? {26'h0, pipe_busy} :
                               hit_ret ? retired_reg : 32'h0000_0000;

  wire flags_t wr_flags = WB_SEL_I[0] ? WB_DAT_I[`FLAGS_W-1:0]
                                      : flags_reg;
  wire rmode_t wr_rm    = WB_SEL_I[1] ?
                          rmode_t'(WB_DAT_I[`PSW_RM_LSB+1:`PSW_RM_LSB])
                                      : rm_reg;

  // ----------------------------------------------------------------
  // status word update
  // ----------------------------------------------------------------
  // set wins over a clear in the same cycle
  assign flags_next = (psw_wr ? wr_flags : flags_reg)
                      | set2_reg[0] | set2_reg[1]
                      | FLAG_SET_IN;
  assign rm_next    = psw_wr ? wr_rm : rm_reg;

  // ----------------------------------------------------------------
  // retired write count
  // ----------------------------------------------------------------
  wire logic [1:0] ret_inc = {1'b0, we3_reg[0]} + {1'b0, we3_reg[1]};

  // ----------------------------------------------------------------
  // bus and status registers
  // ----------------------------------------------------------------
  always_ff @(posedge MCLK or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg     <= 1'b0;
      dat_o_reg   <= 32'h0000_0000;
      flags_reg   <= flags_t'(`PSW_RESET);
      rm_reg      <= RM_NEAREST;
      retired_reg <= 32'h0000_0000;
    end else begin
      ack_reg     <= access & ~ack_reg;
      if (access & ~ack_reg) begin
        dat_o_reg <= rd_mux;
      end
      flags_reg   <= flags_next;
      rm_reg      <= rm_next;
      retired_reg <= retired_reg + {30'h0, ret_inc};
    end
  end

  assign WB_ACK_O  = ack_reg;
  assign WB_DAT_O  = dat_o_reg;
  assign PSW_FLAGS = flags_reg;
  assign PSW_ROUND = rm_reg;

endmodule

`default_nettype wire

// ==== sim/fconv_unit_sva.sv ====
/*
  assertions on the ports of the unsigned float convert unit.
  assumes one clock and the top module's port names.
*/
`default_nettype none
`include "fconv_defs.svh"

module fconv_unit_sva #(
  parameter int DEST_W = 7,
  parameter int ADR_W  = 8
) (
  input wire logic              MCLK,
  input wire logic              RSTN,
  input wire logic              WB_CYC_I,
  input wire logic              WB_STB_I,
  input wire logic              WB_WE_I,
  input wire logic [ADR_W-1:0]  WB_ADR_I,
  input wire logic              WB_ACK_O,
  input wire logic              S1_ISSUE,
  input wire logic [7:0]        S1_OPCODE,
  input wire logic              S1_GUARD_USED,
  input wire logic [31:0]       S1_GUARD,
  input wire logic [DEST_W-1:0] S1_DEST,
  input wire logic              S4_ISSUE,
  input wire logic [7:0]        S4_OPCODE,
  input wire logic              S4_GUARD_USED,
  input wire logic [31:0]       S4_GUARD,
  input wire fconv_pkg::flags_t FLAG_SET_IN,
  input wire logic              S1_WR_EN,
  input wire logic [DEST_W-1:0] S1_WR_DEST,
  input wire logic [31:0]       S1_WR_DATA,
  input wire logic              S4_WR_EN,
  input wire fconv_pkg::flags_t PSW_FLAGS,
  input wire fconv_pkg::rmode_t PSW_ROUND
);
  import fconv_pkg::*;
  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire logic known1 = S1_OPCODE inside {`OPC_FTOU_RZ_FLAGS, `OPC_UTOF,
                                        `OPC_UTOF_FLAGS};
  wire logic known4 = S4_OPCODE inside {`OPC_FTOU_RZ_FLAGS, `OPC_UTOF,
                                        `OPC_UTOF_FLAGS};
  wire logic s1_ok = S1_ISSUE && known1 && (!S1_GUARD_USED || S1_GUARD[0]);
  wire logic s1_no = S1_ISSUE && !s1_ok;
  wire logic s4_ok = S4_ISSUE && known4 && (!S4_GUARD_USED || S4_GUARD[0]);
  wire logic psw_wr = WB_CYC_I && WB_STB_I && WB_WE_I && WB_ACK_O &&
                      WB_ADR_I == `REG_PSW;
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RSTN);
  sequence bus_req; WB_CYC_I && WB_STB_I && !WB_ACK_O; endsequence
  sequence s1_go; s1_ok; endsequence
  sequence inexact_up; $rose(PSW_FLAGS[`FLG_INEXACT]); endsequence
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  ack_follows_a: assert property (bus_req |=> WB_ACK_O)
    else $error("ack missing after request");
  ack_pulse_a: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
  s1_latency_a: assert property (s1_go |-> ##3 S1_WR_EN &&
    S1_WR_DEST == $past(S1_DEST, 3)) else $error("slot 1 write late");
  s1_refuse_a: assert property (s1_no |-> ##3 !S1_WR_EN)
    else $error("slot 1 write without cause");
  s4_latency_a: assert property (s4_ok |-> ##3 S4_WR_EN)
    else $error("slot 4 write late");
  flag_upper_a: assert property ((s1_ok && S1_OPCODE != `OPC_UTOF)
    |-> ##3 S1_WR_DATA[31:7] == 25'h0) else $error("upper bits set");
  flags_sticky_a: assert property (|($past(PSW_FLAGS) & ~PSW_FLAGS)
    |-> $past(psw_wr)) else $error("flag cleared by hardware");
  set_in_or_a: assert property (FLAG_SET_IN != 7'h00 |=>
    (PSW_FLAGS & $past(FLAG_SET_IN)) == $past(FLAG_SET_IN))
    else $error("external flag lost");
  flag_cause_a: assert property (|(PSW_FLAGS & ~$past(PSW_FLAGS) & 7'h7D)
    |-> $past(psw_wr) || $past(FLAG_SET_IN) != 7'h00)
    else $error("flag set without cause");
  inexact_wr_a: assert property (inexact_up |->
    S1_WR_EN || S4_WR_EN || $past(psw_wr) ||
    $past(FLAG_SET_IN[`FLG_INEXACT]))
    else $error("inexact set apart from write");
  round_hold_a: assert property (PSW_ROUND != $past(PSW_ROUND)
    |-> $past(psw_wr)) else $error("mode changed without write");
endmodule

bind fconv_unit fconv_unit_sva #(.DEST_W(DEST_W), .ADR_W(ADR_W))
  i_fconv_unit_sva (.MCLK(MCLK), .RSTN(RSTN), .WB_CYC_I(WB_CYC_I),
  .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
  .WB_ACK_O(WB_ACK_O), .S1_ISSUE(S1_ISSUE), .S1_OPCODE(S1_OPCODE),
  .S1_GUARD_USED(S1_GUARD_USED), .S1_GUARD(S1_GUARD), .S1_DEST(S1_DEST),
  .S4_ISSUE(S4_ISSUE), .S4_OPCODE(S4_OPCODE),
  .S4_GUARD_USED(S4_GUARD_USED), .S4_GUARD(S4_GUARD),
  .FLAG_SET_IN(FLAG_SET_IN), .S1_WR_EN(S1_WR_EN), .S1_WR_DEST(S1_WR_DEST),
  .S1_WR_DATA(S1_WR_DATA), .S4_WR_EN(S4_WR_EN), .PSW_FLAGS(PSW_FLAGS),
  .PSW_ROUND(PSW_ROUND));

`default_nettype wire

// ==== sim/rf_model.sv ====
/*
  register file model that takes the unit's two write ports.
  assumes one-cycle write strobes on the rising clock edge.
*/
`default_nettype none

module rf_model #(
  parameter int DEST_W = 7
) (
  input wire logic              clk,
  input wire logic              we1,
  input wire logic [DEST_W-1:0] dest1,
  input wire logic [31:0]       data1,
  input wire logic              we4,
  input wire logic [DEST_W-1:0] dest4,
  input wire logic [31:0]       data4
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [2**DEST_W];
  // ----------------------------------------------------------------
  // storage, preset to a marker so untouched entries show
  // ----------------------------------------------------------------
  initial for (int i = 0; i < 2**DEST_W; i++) mem[i] = 32'hA5A5A5A5;
  always @(posedge clk) begin
    if (we1) mem[dest1] <= data1;
    if (we4) mem[dest4] <= data4;
  end
endmodule

`default_nettype wire

// ==== sim/test_fconv_unit.sv ====
/*
  testbench of the unsigned float convert unit.
  assumes the rf_model partner and the bound checker.
*/
`default_nettype none
`include "fconv_defs.svh"

module test_fconv_unit;
  import fconv_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, rstn = 0, cyc = 0, stb = 0, we = 0;
  logic [7:0] adr = 0, opc1 = 0, opc4 = 0;
  logic [3:0] sel = 0;
  logic [31:0] dati = 0, src1 = 0, src4 = 0, gd1 = 0, gd4 = 0;
  logic iss1 = 0, iss4 = 0, gu1 = 0, gu4 = 0;
  logic [6:0] dst1 = 0, dst4 = 0, wd1, wd4;
  flags_t fset = 0, pswf;
  rmode_t pswr;
  logic [31:0] dato, wdat1, wdat4;
  logic ack, we1o, we4o;
  int errors = 0, n_checks = 0, retired = 0, ncyc = 0;
  logic [31:0] tsrc [10] = '{32'h40400000, 32'h40247AE1, 32'hFF4FFFFF,
    32'h7F800000, 32'hBFC147AE, 32'h00400000, 32'hFFFFFFFF, 32'hFFBFFFFF,
    32'h4F800000, 32'h4F7FFFFF};
  logic [31:0] texp [10] = '{0, 2, 32'h10, 32'h10, 32'h10, 32'h20, 32'h10,
    32'h10, 32'h10, 0};
  logic [1:0] um [10] = '{0, 0, 0, 0, 0, 1, 1, 2, 3, 0};
  logic [31:0] usrc [10] = '{3, 32'hFFFFFFFF, 32'h7FFFFFFF, 32'h80000000,
    32'h7FFFFFF1, 32'hFFFFFFFF, 32'h7FFFFFFF, 32'h01000001, 32'h01000001,
    32'h01000001};
  logic [31:0] uexp [10] = '{32'h40400000, 32'h4F800000, 32'h4F000000,
    32'h4F000000, 32'h4F000000, 32'h4F7FFFFF, 32'h4EFFFFFF, 32'h4B800001,
    32'h4B800000, 32'h4B800000};
  logic [31:0] uflg [10] = '{0, 2, 2, 0, 2, 2, 2, 2, 2, 2};

  fconv_unit i_fconv_unit (.MCLK(mclk), .RSTN(rstn), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel),
    .WB_DAT_I(dati), .WB_DAT_O(dato), .WB_ACK_O(ack), .S1_ISSUE(iss1),
    .S1_OPCODE(opc1), .S1_SRC(src1), .S1_GUARD_USED(gu1), .S1_GUARD(gd1),
    .S1_DEST(dst1), .S4_ISSUE(iss4), .S4_OPCODE(opc4), .S4_SRC(src4),
    .S4_GUARD_USED(gu4), .S4_GUARD(gd4), .S4_DEST(dst4),
    .FLAG_SET_IN(fset), .S1_WR_EN(we1o), .S1_WR_DEST(wd1),
    .S1_WR_DATA(wdat1), .S4_WR_EN(we4o), .S4_WR_DEST(wd4),
    .S4_WR_DATA(wdat4), .PSW_FLAGS(pswf), .PSW_ROUND(pswr));
  rf_model i_rf_model (.clk(mclk), .we1(we1o), .dest1(wd1), .data1(wdat1),
    .we4(we4o), .dest4(wd4), .data4(wdat4));

  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("ERROR t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge mclk);
    cyc <= 1; stb <= 1; we <= w; adr <= a; dati <= d; sel <= 4'hF;
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    if (n >= 20) errors++;
    q = dato;
    cyc <= 0; stb <= 0; we <= 0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(0, a, 0, q);
    chk(q, e);
  endtask
  task automatic op(input int s, input logic [7:0] o, input logic [31:0] v,
                    input logic g, input logic [31:0] gv,
                    input logic [6:0] d);
    @(posedge mclk);
    if (s == 1) begin
      iss1 <= 1; iss4 <= 0; opc1 <= o; src1 <= v; gu1 <= g; gd1 <= gv;
      dst1 <= d;
    end else begin
      iss4 <= 1; iss1 <= 0; opc4 <= o; src4 <= v; gu4 <= g; gd4 <= gv;
      dst4 <= d;
    end
    if ((!g || gv[0]) &&
        (o inside {`OPC_FTOU_RZ_FLAGS, `OPC_UTOF, `OPC_UTOF_FLAGS}))
      retired++;
  endtask
  task automatic idle;
    @(posedge mclk);
    iss1 <= 0; iss4 <= 0;
    repeat (4) @(posedge mclk);
  endtask

  initial forever #2.5 mclk = ~mclk;
  always @(posedge mclk) begin
    ncyc++;
    if (ncyc == 20000) begin
      errors++;
      stop_test;
    end
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge mclk);
    rstn <= 1;
    repeat (3) @(posedge mclk);
    rd(`REG_PSW, 0);
    rd(`REG_RETIRED, 0);
    wr(8'h0C, 32'hFFFFFFFF);
    rd(8'h0C, 0);
    wr(`REG_RETIRED, 32'h55);
    rd(`REG_RETIRED, 0);
    $display("test bus done");
    for (int i = 0; i < 10; i++)
      op(i % 2 ? 4 : 1, `OPC_FTOU_RZ_FLAGS, tsrc[i], 0, 0, i);
    op(1, `OPC_FTOU_RZ_FLAGS, tsrc[2], 1, 32'h2, 30);
    op(4, `OPC_FTOU_RZ_FLAGS, tsrc[2], 1, 32'h3, 31);
    idle;
    for (int i = 0; i < 10; i++) chk(i_rf_model.mem[i], texp[i]);
    rd(`REG_PIPE, 0);
    chk(i_rf_model.mem[30], 32'hA5A5A5A5);
    chk(i_rf_model.mem[31], 32'h10);
    rd(`REG_PSW, 0);
    for (int m = 0; m < 4; m++) begin
      wr(`REG_PSW, m << 8);
      op(1, `OPC_FTOU_RZ_FLAGS, tsrc[1], 0, 0, 20 + m);
      idle;
      chk(i_rf_model.mem[20 + m], 2);
    end
    $display("test truncation flags done");
    for (int i = 0; i < 10; i++) begin
      wr(`REG_PSW, um[i] << 8);
      op(1, `OPC_UTOF, usrc[i], 0, 0, 40 + i);
      idle;
      chk(i_rf_model.mem[40 + i], uexp[i]);
      rd(`REG_PSW, (um[i] << 8) | uflg[i]);
      chk({pswr, 1'b0, pswf}, (um[i] << 8) | uflg[i]);
      op(4, `OPC_UTOF_FLAGS, usrc[i], 0, 0, 60 + i);
      idle;
      chk(i_rf_model.mem[60 + i], uflg[i]);
      rd(`REG_PSW, (um[i] << 8) | uflg[i]);
    end
    $display("test conversion done");
    wr(`REG_PSW, 0);
    op(1, `OPC_UTOF, 32'hFFFFFFFD, 1, 32'h0, 70);
    op(4, 8'h7D, 32'h3, 0, 0, 72);
    idle;
    chk(i_rf_model.mem[70], 32'hA5A5A5A5);
    chk(i_rf_model.mem[72], 32'hA5A5A5A5);
    rd(`REG_PSW, 0);
    op(4, `OPC_UTOF, 32'hFFFFFFFF, 0, 0, 71);
    @(posedge mclk);
    iss4 <= 0;
    @(posedge mclk);
    fset <= 7'h08;
    @(posedge mclk);
    fset <= 7'h00;
    repeat (3) @(posedge mclk);
    rd(`REG_PSW, 32'h0A);
    chk(i_rf_model.mem[71], 32'h4F800000);
    wr(`REG_PSW, 0);
    rd(`REG_PSW, 0);
    rd(`REG_RETIRED, retired);
    $display("test status word done");
    stop_test;
  end
endmodule

`default_nettype wire
